// ---- design/sac_pkg.sv ----
package sac_pkg;

	// Register byte offsets
	localparam logic [7:0] SAC_OFS_CTRL1  = 8'h00;
	localparam logic [7:0] SAC_OFS_CTRL2  = 8'h04;
	localparam logic [7:0] SAC_OFS_RESULT = 8'h08;
	localparam logic [7:0] SAC_OFS_CMPVAL = 8'h0c;
	localparam logic [7:0] SAC_OFS_CFG    = 8'h10;

	// Channel codes
	localparam logic [4:0] SAC_CH_LAST_PIN = 5'h0b;
	localparam logic [4:0] SAC_CH_LAST_GND = 5'h14;
	localparam logic [4:0] SAC_CH_RSV_LO   = 5'h15;
	localparam logic [4:0] SAC_CH_RSV_HI   = 5'h19;
	localparam logic [4:0] SAC_CH_TEMP     = 5'h1a;
	localparam logic [4:0] SAC_CH_BANDGAP  = 5'h1b;
	localparam logic [4:0] SAC_CH_RSV_TOP  = 5'h1c;
	localparam logic [4:0] SAC_CH_VREFH    = 5'h1d;
	localparam logic [4:0] SAC_CH_VREFL    = 5'h1e;
	localparam logic [4:0] SAC_CH_OFF      = 5'h1f;

	// Clock source codes
	localparam logic [1:0] SAC_SRC_BUS    = 2'h0;
	localparam logic [1:0] SAC_SRC_BUS2   = 2'h1;
	localparam logic [1:0] SAC_SRC_ASYNC  = 2'h2;
	localparam logic [1:0] SAC_SRC_ALT    = 2'h3;

	// Sample lengths less one, in conversion clock ticks; SAR trial bit ends
	localparam logic [4:0] SAC_SAMPLE_SHORT = 5'h03;
	localparam logic [4:0] SAC_SAMPLE_LONG  = 5'h13;
	localparam logic [9:0] SAC_SAR_MSB      = 10'h200;
	localparam logic [9:0] SAC_SAR_LSB      = 10'h001;

	// Control fields
	typedef struct packed {
		logic       coco_ie;
		logic       continuous_conversion_enable;
		logic [4:0] channel_select_field;
	} sac_ctrl1_t;

	typedef struct packed {
		logic cmp_en;
		logic cmp_ge;
		logic hw_trig_en;
	} sac_ctrl2_t;

	typedef struct packed {
		logic       bandgap_buffer_enable;
		logic       long_sample;
		logic       mode8;
		logic [1:0] clock_divide_field;
		logic [1:0] clk_src;
	} sac_cfg_t;

	// Analog mux steering
	typedef struct packed {
		logic       pin_en;
		logic [3:0] pin_idx;
		logic       gnd;
		logic       vdd;
		logic       temp;
		logic       bandgap;
		logic       reserved;
	} sac_mux_t;

	// One-hot converter states
	typedef enum logic [2:0] {
		SAC_IDLE    = 3'b001,
		SAC_SAMPLE  = 3'b010,
		SAC_CONVERT = 3'b100
	} sac_state_t;

endpackage

// ---- design/sac_adc_ctrl.sv ----
`timescale 1ns/1ps

module sac_adc_ctrl
	import sac_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        local_async_conv_clock,
	input  wire logic        external_reference_clock,
	input  wire logic        hw_trigger_input,
	input  wire logic        sar_cmp_high,
	output logic [9:0]       dac_code,
	output logic             sample_en,
	output sac_mux_t         mux_sel,
	output logic             converter_on,
	output logic             bandgap_buffer_enable,
	output logic             alt_clock_request,
	output logic             conv_irq
);

	sac_ctrl1_t ctrl1;
	sac_ctrl2_t ctrl2;
	sac_cfg_t   cfg;
	sac_state_t state;
	logic [9:0] cmp_val;
	logic [9:0] result;
	logic       coco;
	logic [9:0] sar;
	logic [9:0] mask;
	logic [4:0] smp_cnt;
	logic [2:0] div_cnt;
	logic       half_tgl;
	logic       async_q;
	logic       alt_q;
	logic       src_tick;
	logic       conv_tick;
	logic       trig_s1;
	logic       trig_s2;
	logic       trig_s3;
	logic       hw_start;
	logic       wr_ctrl1;
	logic       rd_result;
	logic       acc;
	logic       mapped;
	logic       start;
	logic       finish;
	logic [9:0] final_code;
	logic       cmp_true;

	// Channel code to analog mux steering
	function automatic sac_mux_t decode_ch(input logic [4:0] ch);
		sac_mux_t m;
		m = '0;
		if (ch <= SAC_CH_LAST_PIN)
		begin
			m.pin_en  = 1'b1;
			m.pin_idx = ch[3:0];
		end
		else if (ch <= SAC_CH_LAST_GND)
			m.gnd = 1'b1;
		else if (ch == SAC_CH_TEMP)
			m.temp = 1'b1;
		else if (ch == SAC_CH_BANDGAP)
			m.bandgap = 1'b1;
		else if (ch == SAC_CH_VREFH)
			m.vdd = 1'b1;
		else if (ch == SAC_CH_VREFL)
			m.gnd = 1'b1;
		else if (ch != SAC_CH_OFF)
			m.reserved = 1'b1;
		return m;
	endfunction

	// Byte offset match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	// Bus decode; zero wait states, error on unmapped offsets
	assign acc       = psel & penable;
	assign mapped    = hit(paddr, SAC_OFS_CTRL1) | hit(paddr, SAC_OFS_CTRL2)
		| hit(paddr, SAC_OFS_RESULT) | hit(paddr, SAC_OFS_CMPVAL)
		| hit(paddr, SAC_OFS_CFG);
	assign pready    = penable;
	assign pslverr   = acc & ~mapped;
	assign wr_ctrl1  = acc & pwrite & hit(paddr, SAC_OFS_CTRL1);
	assign rd_result = acc & ~pwrite & hit(paddr, SAC_OFS_RESULT);

	// Read data latched in setup so it comes from a flop
	always_ff @(posedge mclk)
	begin
		if (srst)
			prdata <= '0;
		else if (psel & ~penable & ~pwrite)
		begin
			prdata <= '0;
			if (hit(paddr, SAC_OFS_CTRL1))
				prdata[7:0] <= {coco, ctrl1};
			else if (hit(paddr, SAC_OFS_CTRL2))
				prdata[3:0] <= {state != SAC_IDLE, ctrl2};
			else if (hit(paddr, SAC_OFS_RESULT))
				prdata[9:0] <= result;
			else if (hit(paddr, SAC_OFS_CMPVAL))
				prdata[9:0] <= cmp_val;
			else if (hit(paddr, SAC_OFS_CFG))
				prdata[6:0] <= cfg;
		end
	end

	// Software-written control registers
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			ctrl1   <= '{coco_ie: 1'b0, continuous_conversion_enable: 1'b0,
				channel_select_field: SAC_CH_OFF};
			ctrl2   <= '0;
			cfg     <= '0;
			cmp_val <= '0;
		end
		else if (acc & pwrite)
		begin
			if (hit(paddr, SAC_OFS_CTRL1))
				ctrl1 <= pwdata[6:0];
			if (hit(paddr, SAC_OFS_CTRL2))
				ctrl2 <= pwdata[2:0];
			if (hit(paddr, SAC_OFS_CFG))
				cfg <= pwdata[6:0];
			if (hit(paddr, SAC_OFS_CMPVAL))
				cmp_val <= pwdata[9:0];
		end
	end

	// Source clocks sampled for edge detection
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			async_q  <= 1'b0;
			alt_q    <= 1'b0;
			half_tgl <= 1'b0;
		end
		else
		begin
			async_q  <= local_async_conv_clock;
			alt_q    <= external_reference_clock;
			half_tgl <= ~half_tgl;
		end
	end

	// Source tick; an edge-sampled source must run below half of mclk
	always_comb
	begin
		case (cfg.clk_src)
			SAC_SRC_BUS:   src_tick = 1'b1;
			SAC_SRC_BUS2:  src_tick = half_tgl;
			SAC_SRC_ASYNC: src_tick = local_async_conv_clock & ~async_q;
			SAC_SRC_ALT:   src_tick = external_reference_clock & ~alt_q;
			default:       src_tick = 1'b0;
		endcase
	end

	// Divide by 1, 2, 4 or 8; divider free-runs so no source edge is lost
	always_ff @(posedge mclk)
	begin
		if (srst)
			div_cnt <= '0;
		else if (src_tick)
			div_cnt <= div_cnt + 3'h1;
	end

	always_comb
	begin
		case (cfg.clock_divide_field)
			2'h0:    conv_tick = src_tick;
			2'h1:    conv_tick = src_tick & div_cnt[0];
			2'h2:    conv_tick = src_tick & (&div_cnt[1:0]);
			default: conv_tick = src_tick & (&div_cnt);
		endcase
	end

	// Alternate source held on whenever a conversion needs it; no
	// low-power state gates it, so it runs through wait
	assign alt_clock_request = (state != SAC_IDLE)
		& (cfg.clk_src == SAC_SRC_ALT);

	// Overflow synchroniser; first flop feeds only the second
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			trig_s1 <= 1'b0;
			trig_s2 <= 1'b0;
			trig_s3 <= 1'b0;
		end
		else
		begin
			trig_s1 <= hw_trigger_input;
			trig_s2 <= trig_s1;
			trig_s3 <= trig_s2;
		end
	end

	// Rising edge only, counter irq enable plays no part, no mode gate
	assign hw_start = trig_s2 & ~trig_s3;

	// Start conditions and result shaping
	assign start = (ctrl2.hw_trig_en ? hw_start
		: (wr_ctrl1 & (pwdata[4:0] != SAC_CH_OFF)))
		& (ctrl1.channel_select_field != SAC_CH_OFF || wr_ctrl1);
	assign finish     = (state == SAC_CONVERT) & conv_tick & (mask == SAC_SAR_LSB);
	assign final_code = sar_cmp_high ? (sar | mask) : sar;
	assign cmp_true   = ctrl2.cmp_ge ? (final_code >= cmp_val)
		: (final_code < cmp_val);

	// Conversion sequencer; continues in every low-power mode
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state   <= SAC_IDLE;
			sar     <= '0;
			mask    <= SAC_SAR_MSB;
			smp_cnt <= '0;
		end
		else if (wr_ctrl1 & ~start)
			state <= SAC_IDLE;
		else if (start)
		begin
			state   <= SAC_SAMPLE;
			smp_cnt <= '0;
		end
		else
		begin
			case (state)
				SAC_IDLE:
					state <= SAC_IDLE;
				SAC_SAMPLE:
					if (conv_tick)
					begin
						smp_cnt <= smp_cnt + 5'h01;
						if (smp_cnt == (cfg.long_sample ? SAC_SAMPLE_LONG
							: SAC_SAMPLE_SHORT))
						begin
							state <= SAC_CONVERT;
							sar   <= '0;
							mask  <= SAC_SAR_MSB;
						end
					end
				SAC_CONVERT:
					if (conv_tick)
					begin
						sar  <= final_code;
						mask <= mask >> 1;
						if (finish)
						begin
							smp_cnt <= '0;
							state   <= (ctrl1.continuous_conversion_enable
								&& ctrl1.channel_select_field != SAC_CH_OFF)
								? SAC_SAMPLE : SAC_IDLE;
						end
					end
				default:
					state <= SAC_IDLE;
			endcase
		end
	end

	// Result register, 8-bit mode drops the two low bits
	always_ff @(posedge mclk)
	begin
		if (srst)
			result <= '0;
		else if (finish & (~ctrl2.cmp_en | cmp_true))
			result <= cfg.mode8 ? {2'h0, final_code[9:2]} : final_code;
	end

	// Completion flag; hardware set beats read or write clear
	always_ff @(posedge mclk)
	begin
		if (srst)
			coco <= 1'b0;
		else if (finish & (~ctrl2.cmp_en | cmp_true))
			coco <= 1'b1;
		else if (wr_ctrl1 | rd_result)
			coco <= 1'b0;
	end

	// Interrupt request and analog side outputs
	assign conv_irq              = coco & ctrl1.coco_ie;
	assign mux_sel               = decode_ch(ctrl1.channel_select_field);
	assign converter_on          = state != SAC_IDLE;
	assign sample_en             = state == SAC_SAMPLE;
	assign dac_code              = sar | mask;
	assign bandgap_buffer_enable = cfg.bandgap_buffer_enable;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	property p_trig_start;
		ctrl2.hw_trig_en && !wr_ctrl1 && $rose(trig_s2)
			&& ctrl1.channel_select_field != SAC_CH_OFF
			|=> state == SAC_SAMPLE;
	endproperty
	a_trig_start: assert property (p_trig_start)
		else $error("overflow did not start a conversion");

	property p_one_pulse;
		hw_start |=> !hw_start;
	endproperty
	a_one_pulse: assert property (p_one_pulse)
		else $error("trigger start pulse longer than one cycle");

	property p_write_abort;
		wr_ctrl1 && pwdata[4:0] == SAC_CH_OFF && !finish
			|=> state == SAC_IDLE && !coco;
	endproperty
	a_write_abort: assert property (p_write_abort)
		else $error("all-ones channel write did not stop converter");

	property p_sw_restart;
		wr_ctrl1 && !ctrl2.hw_trig_en && pwdata[4:0] != SAC_CH_OFF
			|=> state == SAC_SAMPLE && smp_cnt == 5'h00;
	endproperty
	a_sw_restart: assert property (p_sw_restart)
		else $error("control write did not restart conversion");

	property p_single_idle;
		finish && !ctrl1.continuous_conversion_enable && !start
			&& !wr_ctrl1 |=> state == SAC_IDLE;
	endproperty
	a_single_idle: assert property (p_single_idle)
		else $error("single conversion did not return to idle");

	property p_coco_cmp;
		$rose(coco) |-> $past(finish)
			&& (!$past(ctrl2.cmp_en) || $past(cmp_true));
	endproperty
	a_coco_cmp: assert property (p_coco_cmp)
		else $error("complete flag set without true compare");

	property p_irq;
		conv_irq == (coco && ctrl1.coco_ie) && (coco || !conv_irq);
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request does not follow flag");

	property p_mode8;
		finish && cfg.mode8 && !ctrl2.cmp_en |=> result[9:8] == 2'h0;
	endproperty
	a_mode8: assert property (p_mode8)
		else $error("8-bit result not right justified");

	property p_pins;
		ctrl1.channel_select_field <= SAC_CH_LAST_PIN
			|-> mux_sel.pin_en && mux_sel.pin_idx
			== ctrl1.channel_select_field[3:0];
	endproperty
	a_pins: assert property (p_pins)
		else $error("pin channel not routed");

	property p_temp;
		ctrl1.channel_select_field == SAC_CH_TEMP |-> mux_sel.temp;
	endproperty
	a_temp: assert property (p_temp)
		else $error("temperature channel not routed");

	property p_alt;
		state != SAC_IDLE && cfg.clk_src == SAC_SRC_ALT |-> alt_clock_request;
	endproperty
	a_alt: assert property (p_alt)
		else $error("alternate clock dropped during conversion");

endmodule

// ---- bench/sac_far_model.sv ----
`timescale 1ns/1ps

// Analog levels, clock sources and periodic counter beside the converter
module sac_far_model
	import sac_pkg::*;
#(
	parameter int PERIOD = 200
)
(
	input  wire logic       mclk,
	input  wire logic       trig_run,
	input  wire logic [9:0] dac_code,
	input  wire sac_mux_t   mux_sel,
	output logic            sar_cmp_high,
	output logic            hw_trigger_input,
	output logic            local_async_conv_clock,
	output logic            external_reference_clock
);
	logic [9:0] vin;
	int         cnt = 0;

	// One fixed level per routed source; reserved reads an odd pattern
	always_comb
	begin
		vin = 10'h2aa;
		if (mux_sel.pin_en)
			vin = {mux_sel.pin_idx, 6'h15};
		else if (mux_sel.gnd)
			vin = 10'h000;
		else if (mux_sel.vdd)
			vin = 10'h3ff;
		else if (mux_sel.temp)
			vin = 10'h1a5;
		else if (mux_sel.bandgap)
			vin = 10'h0d3;
	end

	// Ideal comparator: keep the trial bit while input is not below it
	assign sar_cmp_high = (vin >= dac_code);

	// Free clocks well under half the bus rate, as edge sampling needs
	initial local_async_conv_clock = 1'b0;
	initial external_reference_clock = 1'b0;
	always #40 local_async_conv_clock = ~local_async_conv_clock;
	always #65 external_reference_clock = ~external_reference_clock;

	// Counter wraps every PERIOD cycles; two-cycle overflow pulse
	always_ff @(posedge mclk)
	begin
		if (!trig_run)
			cnt <= 0;
		else
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
	end
	// No interrupt enable gates the overflow output
	assign hw_trigger_input = trig_run && (cnt >= PERIOD - 2);
endmodule

// ---- bench/sar_adc_channel_trigger_control_tb_top.sv ----
`timescale 1ns/1ps

module sar_adc_channel_trigger_control_tb_top
	import sac_pkg::*;
;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        trig_run = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        lclk;
	logic        eclk;
	logic        hwt;
	logic        cmp;
	logic [9:0]  dac_code;
	logic        sample_en;
	sac_mux_t    mux_sel;
	logic        converter_on;
	logic        bg_en;
	logic        alt_req;
	logic        conv_irq;
	logic [31:0] rd;
	logic        err;
	logic        got;
	int          mismatches = 0;
	int          n_tests = 0;

	always #12.5 mclk = ~mclk;

	sac_adc_ctrl dut_u (.mclk(mclk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .local_async_conv_clock(lclk),
		.external_reference_clock(eclk), .hw_trigger_input(hwt),
		.sar_cmp_high(cmp), .dac_code(dac_code), .sample_en(sample_en),
		.mux_sel(mux_sel), .converter_on(converter_on),
		.bandgap_buffer_enable(bg_en), .alt_clock_request(alt_req),
		.conv_irq(conv_irq));

	sac_far_model far_u (.mclk(mclk), .trig_run(trig_run),
		.dac_code(dac_code), .mux_sel(mux_sel), .sar_cmp_high(cmp),
		.hw_trigger_input(hwt), .local_async_conv_clock(lclk),
		.external_reference_clock(eclk));

	task automatic results();
		if (mismatches == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; data and error taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++)
		begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		if (i == 20)
		begin
			mismatches++;
			results();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Poll the complete flag; a required flag that never comes ends the run
	task automatic wait_coco(input int lim, input logic must);
		got = 1'b0;
		for (int i = 0; i < lim && !got; i++)
		begin
			apb(1'b0, SAC_OFS_CTRL1, 32'h0);
			got = (rd[7] === 1'b1);
		end
		if (must && !got)
		begin
			mismatches++;
			results();
		end
	endtask

	function automatic logic [9:0] level(input logic [4:0] ch);
		if (ch <= SAC_CH_LAST_PIN)
			return {ch[3:0], 6'h15};
		if (ch == SAC_CH_TEMP)
			return 10'h1a5;
		if (ch == SAC_CH_BANDGAP)
			return 10'h0d3;
		if (ch == SAC_CH_VREFH)
			return 10'h3ff;
		return 10'h000;
	endfunction

	// Configure, start by software, wait and read back the result
	task automatic conv(input logic [4:0] ch, input logic [6:0] cfg,
		input logic c, input logic [9:0] exp);
		apb(1'b1, SAC_OFS_CFG, {25'h0, cfg});
		apb(1'b1, SAC_OFS_CTRL1, {25'h1, c, ch});
		@(posedge mclk);
		#1;
		check(10'(converter_on), 10'h1);
		check(10'(alt_req), 10'(cfg[1:0] == SAC_SRC_ALT));
		wait_coco(400, 1'b1);
		check(10'(conv_irq), 10'h1);
		apb(1'b0, SAC_OFS_RESULT, 32'h0);
		check(rd[9:0], exp);
		#1;
		check(10'(conv_irq), 10'h0);
	endtask

	task automatic s_reset();
		apb(1'b0, SAC_OFS_CTRL1, 32'h0);
		check(rd[9:0], 10'h01f);
		check(10'(converter_on), 10'h0);
		check(dac_code, SAC_SAR_MSB);
		apb(1'b0, 8'h14, 32'h0);
		check({err, rd[8:0]}, 10'h200);
	endtask

	task automatic s_mux();
		sac_mux_t m;
		for (int c = 0; c < 31; c++)
		begin
			if (c >= SAC_CH_RSV_LO && c <= SAC_CH_RSV_HI || c == 28)
				continue;
			apb(1'b1, SAC_OFS_CTRL1, c);
			#1;
			m = '0;
			m.pin_en = (c <= SAC_CH_LAST_PIN);
			m.pin_idx = m.pin_en ? c[3:0] : 4'h0;
			m.gnd = (c > SAC_CH_LAST_PIN && c <= SAC_CH_LAST_GND) ||
				c == SAC_CH_VREFL;
			m.vdd = (c == SAC_CH_VREFH);
			m.temp = (c == SAC_CH_TEMP);
			m.bandgap = (c == SAC_CH_BANDGAP);
			check(10'(mux_sel), 10'(m));
		end
	endtask

	task automatic s_sources();
		// Each of the four clock sources in turn, divide code equal to source code
		for (int s = 0; s < 4; s++)
			conv(5'(s + 3), {3'h0, 2'(s), 2'(s)}, 1'b0, level(5'(s + 3)));
		check(10'(converter_on), 10'h0);
	endtask

	task automatic s_modes();
		// Long sample and slow clock for the sensor
		conv(SAC_CH_TEMP, 7'h7e, 1'b0, {2'h0, level(SAC_CH_TEMP) >> 2});
		check(10'(bg_en), 10'h1);
		conv(SAC_CH_BANDGAP, 7'h40, 1'b0, level(SAC_CH_BANDGAP));
	endtask

	task automatic s_cmp(input logic [31:0] c2, input logic [9:0] cv,
		input logic exp);
		apb(1'b1, SAC_OFS_CTRL2, c2);
		apb(1'b1, SAC_OFS_CMPVAL, {22'h0, cv});
		apb(1'b1, SAC_OFS_CTRL1, 32'h3);
		wait_coco(30, 1'b0);
		check(10'(got), 10'(exp));
	endtask

	task automatic s_cont_off();
		apb(1'b1, SAC_OFS_CTRL2, 32'h0);
		conv(5'h02, 7'h00, 1'b1, level(5'h02));
		check(10'(converter_on), 10'h1);
		apb(1'b1, SAC_OFS_CTRL1, {27'h1, SAC_CH_OFF});
		repeat (40) @(posedge mclk);
		#1;
		check(10'(converter_on), 10'h0);
		apb(1'b0, SAC_OFS_CTRL1, 32'h0);
		check(rd[9:0], 10'h03f);
	endtask

	task automatic s_abort();
		apb(1'b1, SAC_OFS_CFG, 32'hc);
		apb(1'b1, SAC_OFS_CTRL1, 32'h4);
		repeat (30) @(posedge mclk);
		conv(5'h07, 7'h0c, 1'b0, level(5'h07));
	endtask

	task automatic s_hw();
		int i;
		apb(1'b1, SAC_OFS_CFG, 32'h0);
		apb(1'b1, SAC_OFS_CTRL2, 32'h1);
		apb(1'b1, SAC_OFS_CTRL1, 32'h9);
		repeat (40) @(posedge mclk);
		#1;
		check(10'(converter_on), 10'h0);
		trig_run <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			for (i = 0; i < 300 && converter_on !== 1'b1; i++)
				@(posedge mclk);
			check(10'(i < 300), 10'h1);
			wait_coco(100, 1'b1);
			apb(1'b0, SAC_OFS_RESULT, 32'h0);
			check(rd[9:0], level(5'h09));
		end
		trig_run <= 1'b0;
	endtask

	initial
	begin
		repeat (20) @(posedge mclk);
		srst <= 1'b0;
		s_reset();
		s_mux();
		s_sources();
		s_modes();
		s_cmp(32'h4, level(5'h03) + 10'h1, 1'b1);
		s_cmp(32'h4, level(5'h03), 1'b0);
		s_cmp(32'h6, level(5'h03), 1'b1);
		s_cont_off();
		s_abort();
		s_hw();
		results();
	end
endmodule
